// file: fts_sram_top.sv
/*
  Flow-through burst SRAM access logic: strobes, chip selects, burst
  counter, byte and global writes, data float control and memory array.
  Assumes all pins except the output enable are synchronous to mclk;
  the shared data bus is resolved outside from dq_out and dq_oe_n.
*/
`timescale 1ns/1ns
`default_nettype none
`include "fts_cfg.svh"

module fts_sram_top #(
  parameter int ADDR_W     = `FTS_ADDR_W,
  parameter int LANE_W     = `FTS_LANE_W,
  parameter int LANES      = `FTS_LANES,
  parameter bit HAS_THIRD  = 1'b1
) (
  // Clock and reset
  input  wire logic                    mclk,
  input  wire logic                    nrst,
  // Address and strobes
  input  wire logic [ADDR_W-1:0]       addr,
  input  wire logic                    processor_addr_strobe_n,
  input  wire logic                    controller_addr_strobe_n,
  input  wire logic                    burst_advance_n,
  // Chip selects
  input  wire logic                    primary_select_n,
  input  wire logic                    depth_select_hi,
  input  wire logic                    depth_select_lo_n,
  // Write controls
  input  wire logic                    global_write_n,
  input  wire logic                    byte_write_enable_n,
  input  wire logic [LANES-1:0]        byte_lane_select_n,
  // Output enable and burst order strap
  input  wire logic                    output_enable_n,
  input  wire logic                    burst_order_sel,
  // Shared data bus, parity bit at the top of each lane
  input  wire logic [LANE_W*LANES-1:0] dq_in,
  output var  logic [LANE_W*LANES-1:0] dq_out,
  output logic                         dq_oe_n,
  // Test port
  input  wire logic                    test_clk,
  input  wire logic                    test_data_in,
  input  wire logic                    test_mode_sel,
  output logic                         test_data_out
);

  localparam int DATA_W  = LANE_W * LANES;
  localparam int DEPTH   = 2 ** ADDR_W;
  localparam int CDV_CYC = `FTS_CDV_CYC;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (ADDR_W < 3 || ADDR_W > 24) begin : g_bad_addr
    $error("ADDR_W must lie between 3 and 24");
  end
  if (LANE_W < 1 || LANES < 1) begin : g_bad_lanes
    $error("LANE_W and LANES must be positive");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  fts_pkg::fts_state_e      st_r;
  logic [ADDR_W-3:0]        addr_hi_r;
  logic                     float_r;
  logic                     order_r;
  logic                     strap_done_r;
  logic [DATA_W-1:0]        mem [0:DEPTH-1];

  logic                     selected;
  logic                     proc_hit;
  logic                     ctrl_hit;
  logic                     start;
  logic                     desel;
  logic                     cont;
  logic                     wr_req;
  logic [LANES-1:0]         wmask;
  logic                     wr_now;
  logic                     rd_now;
  fts_pkg::fts_boff_t       low_addr;
  logic [ADDR_W-1:0]        full_addr;
  logic [DATA_W-1:0]        rd_word;
  logic [DATA_W-1:0]        wr_word;

  fts_burst_if              bif ();

  // ----------------------------------------------------------------
  // Burst counter
  // ----------------------------------------------------------------
  fts_burst_ctr u_ctr (
    .mclk (mclk),
    .nrst (nrst),
    .bus  (bif.ctr)
  );

  // ----------------------------------------------------------------
  // Test port
  // ----------------------------------------------------------------
  fts_test_port u_tap (
    .mclk          (mclk),
    .nrst          (nrst),
    .test_clk      (test_clk),
    .test_data_in  (test_data_in),
    .test_mode_sel (test_mode_sel),
    .test_data_out (test_data_out)
  );

  // ----------------------------------------------------------------
  // Burst order strap, caught once after reset release
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      order_r      <= `FTS_ORDER_RST;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      order_r      <= burst_order_sel;
      strap_done_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Start decode
  // ----------------------------------------------------------------
  assign selected = ~primary_select_n & depth_select_hi & (HAS_THIRD ? ~depth_select_lo_n : 1'b1);
  assign proc_hit = ~processor_addr_strobe_n & ~primary_select_n;
  assign ctrl_hit = ~controller_addr_strobe_n & ~proc_hit;
  assign start    = (proc_hit | ctrl_hit) & selected;
  assign desel    = (proc_hit | ctrl_hit) & ~selected;
  assign cont     = (st_r == fts_pkg::FTS_ACTIVE) & ~proc_hit & ~ctrl_hit;

  // ----------------------------------------------------------------
  // Write qualification
  // ----------------------------------------------------------------
  always_comb begin
    if (!global_write_n) begin
      wmask = '1;
    end else if (!byte_write_enable_n) begin
      wmask = ~byte_lane_select_n;
    end else begin
      wmask = '0;
    end
  end

  assign wr_req = |wmask;
  // Processor-strobe start never writes: write inputs ignored that cycle
  assign wr_now = ((ctrl_hit & selected) | cont) & wr_req;
  assign rd_now = (proc_hit & selected) | (((ctrl_hit & selected) | cont) & ~wr_req);

  // ----------------------------------------------------------------
  // Address path
  // ----------------------------------------------------------------
  assign bif.load       = start;
  assign bif.step       = cont & ~burst_advance_n;
  assign bif.start      = addr[1:0];
  assign bif.interleave = (order_r == `FTS_ORDER_ILV);

  assign low_addr  = bif.step ? bif.nxt : bif.cur;
  assign full_addr = start ? addr : {addr_hi_r, low_addr};

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      addr_hi_r <= '0;
    end else if (start) begin
      addr_hi_r <= addr[ADDR_W-1:2];
    end
  end

  // ----------------------------------------------------------------
  // Access state
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_r <= fts_pkg::FTS_IDLE;
    end else begin
      case (st_r)
        fts_pkg::FTS_IDLE: begin
          if (start) begin
            st_r <= fts_pkg::FTS_ACTIVE;
          end
        end
        fts_pkg::FTS_ACTIVE: begin
          if (desel) begin
            st_r <= fts_pkg::FTS_IDLE;
          end
        end
        default: begin
          st_r <= fts_pkg::FTS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Memory array, self-timed write at the capturing edge
  // ----------------------------------------------------------------
  assign rd_word = mem[full_addr];

  for (genvar l = 0; l < LANES; l++) begin : g_lane
    assign wr_word[l*LANE_W +: LANE_W] = wmask[l] ? dq_in[l*LANE_W +: LANE_W] : rd_word[l*LANE_W +: LANE_W];
  end

  always_ff @(posedge mclk) begin
    if (wr_now) begin
      mem[full_addr] <= wr_word;
    end
  end

  // ----------------------------------------------------------------
  // Read data, launched on the capturing edge itself
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dq_out <= '0;
    end else if (rd_now) begin
      dq_out <= rd_word;
    end
  end

  // ----------------------------------------------------------------
  // Data float control
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      float_r <= `FTS_FLOAT_RST;
    end else if (desel || wr_now) begin
      float_r <= 1'b1;
    end else if (rd_now) begin
      float_r <= 1'b0;
    end
  end

  // Output enable gates the drivers without the clock
  assign dq_oe_n = float_r | output_enable_n;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_proc_strobe_ignored: assert property (@(posedge mclk) disable iff (!nrst)
    (primary_select_n && !processor_addr_strobe_n && controller_addr_strobe_n
     && st_r == fts_pkg::FTS_IDLE) |=> (st_r == fts_pkg::FTS_IDLE))
    else $error("processor strobe acted while primary select inactive");

  chk_read_start_drives: assert property (@(posedge mclk) disable iff (!nrst)
    (proc_hit && selected && !output_enable_n) |=> (!dq_oe_n || output_enable_n))
    else $error("read start did not enable the data drivers");

  chk_read_data_flow: assert property (@(posedge mclk) disable iff (!nrst)
    (rd_now && !wr_now) |-> ##[1:CDV_CYC] (dq_out == $past(rd_word)))
    else $error("read data not presented in the capturing cycle");

  chk_write_floats: assert property (@(posedge mclk) disable iff (!nrst)
    wr_now |=> (float_r && dq_oe_n))
    else $error("data lines driven after a write was detected");

  chk_proc_first_ignored: assert property (@(posedge mclk) disable iff (!nrst)
    (!processor_addr_strobe_n && !controller_addr_strobe_n && !global_write_n
     && selected) |-> (!wr_now ##1 !float_r))
    else $error("write inputs honoured on a processor strobe start");

  chk_global_all_lanes: assert property (@(posedge mclk) disable iff (!nrst)
    (wr_now && !global_write_n) |=> (mem[$past(full_addr)] == $past(dq_in)))
    else $error("global write left a lane unwritten");

  chk_start_latches: assert property (@(posedge mclk) disable iff (!nrst)
    start |=> (addr_hi_r == $past(addr[ADDR_W-1:2]) && bif.cur == $past(addr[1:0])))
    else $error("accepted strobe did not latch the address");

  chk_linear_step: assert property (@(posedge mclk) disable iff (!nrst)
    (bif.step && !bif.interleave) |=> (bif.cur == $past(bif.cur) + 2'h1))
    else $error("linear burst did not advance by one");

  chk_interleave_step: assert property (@(posedge mclk) disable iff (!nrst)
    (bif.step && bif.interleave && $past(bif.load)) |=> (bif.cur == ($past(bif.cur) ^ 2'h1)))
    else $error("interleaved burst second address wrong");

  chk_oe_async_float: assert property (@(posedge mclk) disable iff (!nrst)
    output_enable_n |-> dq_oe_n)
    else $error("drivers on while output enable high");

  chk_strap_frozen: assert property (@(posedge mclk) disable iff (!nrst)
    strap_done_r |=> $stable(order_r))
    else $error("burst order changed after the strap was taken");

endmodule

`default_nettype wire

// file: fts_cfg.svh
/*
  Constants of the flow-through burst SRAM: array shape, burst counter,
  strap encoding, test port width and timing counts.
  Assumes inclusion by bare name from each design file that needs it.
*/
`ifndef FTS_CFG_SVH
`define FTS_CFG_SVH

// ----------------------------------------------------------------
// Array shape
// ----------------------------------------------------------------
`define FTS_ADDR_W        18
`define FTS_LANE_W        9
`define FTS_LANES         4
`define FTS_BOFF_W        2

// ----------------------------------------------------------------
// Burst order strap encoding and reset values
// ----------------------------------------------------------------
`define FTS_ORDER_LINEAR  1'b0
`define FTS_ORDER_ILV     1'b1
`define FTS_ORDER_RST     1'b1
`define FTS_FLOAT_RST     1'b1

// ----------------------------------------------------------------
// Test port and timing
// ----------------------------------------------------------------
`define FTS_SCAN_W        8
`define FTS_CLOCK_TO_DATA_VALID_PS      6500
`define FTS_CLK_PS        40000
`define FTS_CDV_CYC       (((`FTS_CLOCK_TO_DATA_VALID_PS / `FTS_CLK_PS) < 1) ? 1 : (`FTS_CLOCK_TO_DATA_VALID_PS / `FTS_CLK_PS))

`endif

// file: fts_pkg.sv
/*
  Types shared by the flow-through burst SRAM modules.
  Assumes nothing of its surroundings.
*/
package fts_pkg;

  typedef enum logic [1:0] {
    FTS_IDLE,
    FTS_ACTIVE
  } fts_state_e;

  typedef logic [1:0] fts_boff_t;

endpackage

// file: fts_burst_if.sv
/*
  Link between the access controller and the two-bit burst counter.
  Assumes the controller and counter share one clock.
*/
`timescale 1ns/1ns
`default_nettype none

interface fts_burst_if;
  logic               load;
  logic               step;
  logic               interleave;
  fts_pkg::fts_boff_t start;
  fts_pkg::fts_boff_t cur;
  fts_pkg::fts_boff_t nxt;

  modport ctl (output load, output step, output interleave, output start, input cur, input nxt);
  modport ctr (input load, input step, input interleave, input start, output cur, output nxt);
endinterface

`default_nettype wire

// file: fts_burst_ctr.sv
/*
  Two-bit wraparound burst counter, linear or interleaved order.
  Assumes load and step come from the access controller on mclk.
*/
`timescale 1ns/1ns
`default_nettype none

module fts_burst_ctr (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic nrst,
  // Controller side
  fts_burst_if.ctr  bus
);

  fts_pkg::fts_boff_t base_r;
  fts_pkg::fts_boff_t cnt_r;
  fts_pkg::fts_boff_t cnt_inc;

  assign cnt_inc = cnt_r + 2'h1;

  // ----------------------------------------------------------------
  // Counter state
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      base_r <= 2'h0;
      cnt_r  <= 2'h0;
    end else if (bus.load) begin
      base_r <= bus.start;
      cnt_r  <= 2'h0;
    end else if (bus.step) begin
      cnt_r  <= cnt_inc;
    end
  end

  // ----------------------------------------------------------------
  // Address order
  // ----------------------------------------------------------------
  assign bus.cur = bus.interleave ? (base_r ^ cnt_r) : (base_r + cnt_r);
  assign bus.nxt = bus.interleave ? (base_r ^ cnt_inc) : (base_r + cnt_inc);

  chk_ctr_holds: assert property (@(posedge mclk) disable iff (!nrst)
    (!bus.load && !bus.step) |=> $stable(cnt_r))
    else $error("burst counter moved without a step");

endmodule

`default_nettype wire

// file: fts_test_port.sv
/*
  Serial test port edge behaviour: an eight-bit shift path.
  Assumes the test clock is a plain input synchronous to mclk and slower.
*/
`timescale 1ns/1ns
`default_nettype none
`include "fts_cfg.svh"

module fts_test_port #(
  parameter int SCAN_W = `FTS_SCAN_W
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic nrst,
  // Test pins
  input  wire logic test_clk,
  input  wire logic test_data_in,
  input  wire logic test_mode_sel,
  output var  logic test_data_out
);

  logic              tck_d_r;
  logic              tms_s_r;
  logic [SCAN_W-1:0] sh_r;
  logic              tck_rise;
  logic              tck_fall;

  if (SCAN_W < 2) begin : g_bad_width
    $error("SCAN_W must be at least two");
  end

  assign tck_rise = test_clk & ~tck_d_r;
  assign tck_fall = ~test_clk & tck_d_r;

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tck_d_r <= 1'b0;
    end else begin
      tck_d_r <= test_clk;
    end
  end

  // ----------------------------------------------------------------
  // Sample on rising test clock
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tms_s_r <= 1'b1;
      sh_r    <= '0;
    end else if (tck_rise) begin
      tms_s_r <= test_mode_sel;
      sh_r    <= test_mode_sel ? sh_r : {test_data_in, sh_r[SCAN_W-1:1]};
    end
  end

  // ----------------------------------------------------------------
  // Drive on falling test clock
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      test_data_out <= 1'b0;
    end else if (tck_fall) begin
      test_data_out <= sh_r[0];
    end
  end

  chk_tdo_on_fall: assert property (@(posedge mclk) disable iff (!nrst)
    (!tck_fall) |=> $stable(test_data_out))
    else $error("serial output changed off a falling test clock");

  chk_tms_on_rise: assert property (@(posedge mclk) disable iff (!nrst)
    tck_rise |=> (tms_s_r == $past(test_mode_sel)))
    else $error("mode select not sampled on rising test clock");

endmodule

`default_nettype wire

// file: fts_host_model.sv
/*
  Host model of the memory bus: one call of op is one bus cycle.
  Assumes op is called just after a rising mclk edge.
*/
`timescale 1ns/1ns
`default_nettype none

module fts_host_model (
  // Clock and bench control
  input  wire logic        mclk,
  input  wire logic        oe_req_n,
  // Address, strobes and select
  output var  logic [17:0] addr,
  output var  logic        processor_addr_strobe_n,
  output var  logic        controller_addr_strobe_n,
  output var  logic        burst_advance_n,
  output var  logic        primary_select_n,
  // Writes, output enable and data
  output var  logic        global_write_n,
  output var  logic        byte_write_enable_n,
  output var  logic [3:0]  byte_lane_select_n,
  output wire logic        output_enable_n,
  output var  logic [35:0] dq_in
);
  logic wr_q;

  // Output enable held off while write data is on the bus
  assign output_enable_n = wr_q | oe_req_n;

  initial begin
    wr_q = 1'b0;
    addr = 18'h0;
    {processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n} = 3'h7;
    {primary_select_n, global_write_n, byte_write_enable_n} = 3'h7;
    byte_lane_select_n = 4'hf;
    dq_in = 36'h0;
  end

  // k = {proc, ctrl, advance, primary, global, byte enable}
  task automatic op(input logic [5:0] k, input logic [3:0] l, input logic [17:0] a, input logic [35:0] d);
    {processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n} <= k[5:3];
    {primary_select_n, global_write_n, byte_write_enable_n} <= k[2:0];
    byte_lane_select_n <= l;
    addr <= a;
    wr_q <= k[5] & ~(k[1] & k[0]);
    // A released bus shows the inverse of its last value
    dq_in <= (k[5] & ~(k[1] & k[0])) ? d : ~dq_in;
    @(posedge mclk);
    #1;
  endtask
endmodule

`default_nettype wire

// file: flow_through_burst_sram_access_tb_top.sv
/*
  Self-checking bench of the SRAM access logic, linear and interleaved.
  Assumes fts_host_model drives the bus and a reference memory here.
*/
`timescale 1ns/1ns
`default_nettype none

module flow_through_burst_sram_access_tb_top;
  logic              mclk, nrst, mode, oe_req_n, tck, tdi, dsh, dsl_n;
  logic [35:0]       mem [logic [17:0]];
  int                err_total, checks, cyc;
  wire logic [17:0]  addr;
  wire logic [35:0]  dq_in, dq_out;
  wire logic [3:0]   bls_n;
  wire logic         p_n, c_n, v_n, s_n, g_n, b_n, oe_n, dq_oe_n, tdo;

  fts_host_model u_fts_host_model (.mclk(mclk), .oe_req_n(oe_req_n), .addr(addr),
    .processor_addr_strobe_n(p_n), .controller_addr_strobe_n(c_n), .burst_advance_n(v_n),
    .primary_select_n(s_n), .global_write_n(g_n), .byte_write_enable_n(b_n),
    .byte_lane_select_n(bls_n), .output_enable_n(oe_n), .dq_in(dq_in));

  fts_sram_top u_fts_sram_top (.mclk(mclk), .nrst(nrst), .addr(addr),
    .processor_addr_strobe_n(p_n), .controller_addr_strobe_n(c_n), .burst_advance_n(v_n),
    .primary_select_n(s_n), .depth_select_hi(dsh), .depth_select_lo_n(dsl_n),
    .global_write_n(g_n), .byte_write_enable_n(b_n), .byte_lane_select_n(bls_n),
    .output_enable_n(oe_n), .burst_order_sel(mode), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe_n(dq_oe_n), .test_clk(tck), .test_data_in(tdi), .test_mode_sel(1'b0),
    .test_data_out(tdo));

  // ----------------------------------------------------------------
  // Clock, timeout and checking helpers
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      err_total++;
      summarize();
    end
  end

  task automatic chk(input string n, input logic [35:0] e, input logic [35:0] s);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  function automatic logic [1:0] nxt(input logic md, input logic [1:0] s, input logic [1:0] k);
    return md ? s ^ k : s + k;
  endfunction

  function automatic logic [35:0] rnd();
    return {4'($urandom), $urandom};
  endfunction

  task automatic reset(input logic md);
    nrst <= 1'b0;
    mode <= md;
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  task automatic summarize();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence, once per burst order
  // ----------------------------------------------------------------
  initial begin
    logic [17:0] a;
    logic [35:0] d;
    logic [3:0]  l;
    logic [1:0]  st, cur;
    logic [15:0] tv;
    nrst = 1'b0;
    mode = 1'b1;
    oe_req_n = 1'b0;
    {tck, tdi, dsh, dsl_n} = 4'h2;
    err_total = 0;
    checks = 0;
    cyc = 0;
    void'($urandom(32'h9a50));
    for (int m = 0; m < 2; m++) begin
      reset(m[0]);
      a = 18'($urandom) & 18'h3fffc;
      for (int i = 0; i < 4; i++) begin
        d = rnd();
        mem[a + 18'(i)] = d;
        u_fts_host_model.op(6'b101001, 4'hf, a + 18'(i), d);
        chk("float", 36'h1, 36'(dq_oe_n));
      end
      l = 4'($urandom) & 4'he;
      d = rnd();
      for (int k = 0; k < 4; k++) if (!l[k]) mem[a][k*9 +: 9] = d[k*9 +: 9];
      u_fts_host_model.op(6'b101010, l, a, d);
      chk("float", 36'h1, 36'(dq_oe_n));
      st = 2'($urandom);
      u_fts_host_model.op(6'b011000, 4'h0, a | 18'(st), rnd());
      chk("read", mem[a | 18'(st)], dq_out);
      chk("drive", 36'h0, 36'(dq_oe_n));
      for (int k = 1; k < 4; k++) begin
        if (k == 2) begin
          u_fts_host_model.op(6'b111011, 4'hf, a, rnd());
          chk("hold", mem[a | 18'(nxt(m[0], st, 2'd1))], dq_out);
        end
        u_fts_host_model.op(6'b110011, 4'hf, a, rnd());
        chk("burst", mem[a | 18'(nxt(m[0], st, 2'(k)))], dq_out);
      end
      cur = nxt(m[0], st, 2'd3);
      d = rnd();
      mem[a | 18'(cur)] = d;
      u_fts_host_model.op(6'b111001, 4'hf, a, d);
      chk("float", 36'h1, 36'(dq_oe_n));
      u_fts_host_model.op(6'b001001, 4'hf, a, rnd());
      chk("read", mem[a], dq_out);
      chk("drive", 36'h0, 36'(dq_oe_n));
      u_fts_host_model.op(6'b001111, 4'hf, a, rnd());
      chk("deselect", 36'h1, 36'(dq_oe_n));
      u_fts_host_model.op(6'b010111, 4'hf, a, rnd());
      chk("ignored", 36'h1, 36'(dq_oe_n));
      oe_req_n = 1'b1;
      u_fts_host_model.op(6'b101011, 4'hf, a | 18'(cur), rnd());
      chk("oe off", 36'h1, 36'(dq_oe_n));
      #5 oe_req_n = 1'b0;
      #1 chk("oe on", 36'h0, 36'(dq_oe_n));
      chk("read", mem[a | 18'(cur)], dq_out);
      for (int q = 0; q < 2; q++) begin
        u_fts_host_model.op(6'b101011, 4'hf, a, rnd());
        chk("drive", 36'h0, 36'(dq_oe_n));
        {dsh, dsl_n} <= q ? 2'b11 : 2'b00;
        u_fts_host_model.op(6'b101011, 4'hf, a, rnd());
        chk("depth", 36'h1, 36'(dq_oe_n));
        {dsh, dsl_n} <= 2'b10;
      end
      tv = 16'($urandom);
      for (int j = 0; j < 16; j++) begin
        tdi <= tv[j];
        tck <= 1'b1;
        repeat (2) @(posedge mclk);
        tck <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        if (j > 6) chk("tdo", 36'(tv[j-7]), 36'(tdo));
      end
      $display("test mode %0d done", m);
    end
    summarize();
  end
endmodule

`default_nettype wire
